// file: design/ast_pkg.sv
// Package: constants, types and register map of the acquisition-start trigger controller
// Notes on behaviour
// - Armed mode starts waiting; frame triggers ignored
// - Valid start trigger moves to frame wait
// - Count frames; at programmed count rearm
// - Frame count range is 1 to 255
// - Writing 1 to soft trigger injects event
// - Soft trigger register self clears when done
// - Soft command routed only when selector matches
// - Only the selected hardware input triggers
// - Edge polarity chooses rising or falling
// - Hardware trigger delayed 0 to 1000000 us
// - No delay for software or disabled mode
// - Each frame trigger in frame wait starts frame
// - CC lines are active low, inverted
package ast_pkg;
   // Register offsets (byte addresses)
   localparam logic [7:0] ADDR_MODE       = 8'h00; // Enable trigger mode
   localparam logic [7:0] ADDR_SOURCE     = 8'h04; // Source select
   localparam logic [7:0] ADDR_ACTIVATION = 8'h08; // Edge select
   localparam logic [7:0] ADDR_FRAME_CNT  = 8'h0c; // Frames per acquisition
   localparam logic [7:0] ADDR_DELAY      = 8'h10; // Delay in microseconds
   localparam logic [7:0] ADDR_SOFT_TRIG  = 8'h14; // Software trigger strobe
   localparam logic [7:0] ADDR_SELECTOR   = 8'h18; // Trigger-kind selector
   localparam logic [7:0] ADDR_GPIO_DIR   = 8'h1c; // GPIO direction
   localparam logic [7:0] ADDR_STATUS     = 8'h20; // Status, read only
   // Source encodings
   localparam logic [2:0] SRC_SOFTWARE = 3'h0;
   localparam logic [2:0] SRC_LINE1    = 3'h1;
   localparam logic [2:0] SRC_CC1      = 3'h2;
   localparam logic [2:0] SRC_CC2      = 3'h3;
   localparam logic [2:0] SRC_CC3      = 3'h4;
   // Selector encodings
   localparam logic [1:0] SEL_ACQ_START   = 2'h0;
   localparam logic [1:0] SEL_FRAME_START = 2'h1;
   // Field widths and limits
   localparam int unsigned FRAME_CNT_W   = 8;
   localparam int unsigned DELAY_W       = 20;
   localparam logic [7:0]  FRAME_CNT_MIN = 8'h01;
   localparam logic [7:0]  FRAME_CNT_RST = 8'h01;
   localparam logic [19:0] DELAY_MAX_US  = 20'hf4240; // 1000000 us
   // Timing
   localparam int unsigned CLK_MHZ       = 100;
   localparam int unsigned CYC_PER_US    = CLK_MHZ; // 1 us at 100 MHz
   localparam int unsigned STATUS_W      = 4;
   // Controller states, Gray along the arm path
   typedef enum logic [1:0] {
      ST_IDLE      = 2'b00,
      ST_WAIT_ACQ  = 2'b01,
      ST_WAIT_FRM  = 2'b11
   } ast_state_type;
   // Register bus request
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } ast_bus_type;
   // Hardware trigger inputs
   typedef struct packed {
      logic line1;
      logic cc1_n;
      logic cc2_n;
      logic cc3_n;
   } ast_hw_type;
endpackage

// file: design/ast_trigger_ctrl.sv
// Acquisition-start trigger controller: registers, edge detect, delay, arm state machine
`timescale 1ns/10ps
`default_nettype none
module ast_trigger_ctrl
   import ast_pkg::*;
#(
   parameter int unsigned CYC_US = CYC_PER_US // Clock cycles per microsecond
) (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire ast_bus_type bus,
   output logic [31:0]      rdata,
   input  wire ast_hw_type  hw_in,
   input  wire logic        frame_trig,
   output logic             frame_start,
   output logic             acq_armed,
   output logic             ext_acq_start_pulse,
   output logic             gpio_direction_select
);
   // Prescaler is 16 bits, so larger ratios cannot be counted
   if (CYC_US < 1 || CYC_US > 65535) begin : g_cyc_us_check
      $error("CYC_US out of range");
   end

   // Configuration registers, written only from the register bus
   logic                   mode_q;       // Trigger mode enabled
   logic [2:0]             source_q;     // Selected source
   logic                   falling_q;    // 1 = falling edge
   logic [FRAME_CNT_W-1:0] frame_cnt_q;  // Frames per acquisition
   logic [DELAY_W-1:0]     delay_q;      // Delay in us
   logic [1:0]             selector_q;   // Trigger-kind selector
   logic                   gpio_dir_q;   // 1 = input
   // Command and controller state
   logic                   soft_q;       // Soft trigger pending
   ast_state_type          state_q;      // Controller state
   logic [FRAME_CNT_W-1:0] frames_q;     // Frames taken so far
   // Output registers; every data output except acq_armed leaves from a flop
   logic [31:0]            rdata_q;      // Read data register
   logic                   frame_start_q; // Accepted frame pulse
   logic                   ext_pulse_q;  // Detected edge, before delay

   // Write decode helper
   // Shared by every register write below
   function automatic logic wr_hit(input ast_bus_type b, input logic [7:0] a);
      return b.wr && (b.addr == a);
   endfunction

   // Configuration writes
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         // Software is the default source, so no pin can arm after reset
         mode_q      <= 1'b0;
         source_q    <= SRC_SOFTWARE;
         falling_q   <= 1'b0;
         frame_cnt_q <= FRAME_CNT_RST;
         delay_q     <= '0;
         selector_q  <= SEL_ACQ_START;
         gpio_dir_q  <= 1'b0;
      end else begin
         // Mode off also stops the delay timer and drops the arm state
         if (wr_hit(bus, ADDR_MODE)) begin
            mode_q <= bus.wdata[0];
         end
         // Codes above the last source select nothing at all
         if (wr_hit(bus, ADDR_SOURCE)) begin
            source_q <= bus.wdata[2:0];
         end
         // Polarity only; both edges at once is not offered
         if (wr_hit(bus, ADDR_ACTIVATION)) begin
            falling_q <= bus.wdata[0];
         end
         // Zero is kept at the floor, so the count reads back as 1
         if (wr_hit(bus, ADDR_FRAME_CNT)) begin
            frame_cnt_q <= (bus.wdata[7:0] < FRAME_CNT_MIN) ? FRAME_CNT_MIN : bus.wdata[7:0];
         end
         // Values above the top are clamped
         if (wr_hit(bus, ADDR_DELAY)) begin
            delay_q <= (bus.wdata[31:0] > 32'(DELAY_MAX_US)) ? DELAY_MAX_US : bus.wdata[19:0];
         end
         // Selector only steers where soft commands go
         if (wr_hit(bus, ADDR_SELECTOR)) begin
            selector_q <= bus.wdata[1:0];
         end
         // Line must be an input before it can trigger
         if (wr_hit(bus, ADDR_GPIO_DIR)) begin
            gpio_dir_q <= bus.wdata[0];
         end
      end
   end
   // Direction goes out to the pin driver
   assign gpio_direction_select = gpio_dir_q;

   // Software trigger command, only for acquisition-start selector
   // A command that finds the mode off or a hardware source is lost;
   // the register still clears, so software never waits on it
   logic soft_fire; // Command reaches the state machine
   assign soft_fire = soft_q && mode_q && (source_q == SRC_SOFTWARE);
   // Pending bit lives one cycle: set by the write, cleared after use
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         soft_q <= 1'b0;
      end else if (wr_hit(bus, ADDR_SOFT_TRIG) && bus.wdata[0]
                   && selector_q == SEL_ACQ_START) begin
         // Write of 1 injects a single event
         soft_q <= 1'b1;
      end else begin
         // Event consumed in its only cycle
         soft_q <= 1'b0;
      end
   end

   // Two-flop synchronisers on all hardware inputs
   // Pins are treated as asynchronous here even though the port is clocked;
   // the cost is two cycles of latency on every hardware trigger
   logic [3:0] sync1_q; // First stage, may go metastable
   logic [3:0] sync2_q; // Second stage, safe to use
   logic [3:0] prev_q;  // Last cycle's settled level
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         // Zero is the idle sense of every line, so no false edge follows reset
         sync1_q <= 4'h0;
         sync2_q <= 4'h0;
         prev_q  <= 4'h0;
      end else begin
         // CC lines inverted to active-high sense
         sync1_q <= {hw_in.line1, ~hw_in.cc1_n, ~hw_in.cc2_n, ~hw_in.cc3_n};
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   // Pick the selected line only
   logic sel_now;  // Selected input, settled level
   logic sel_prev; // Same input one cycle back
   logic sel_ok;   // Selected input may trigger
   // Unselected lines never reach the edge detector
   always_comb begin
      // Defaults keep the software source edge-free
      sel_now  = 1'b0;
      sel_prev = 1'b0;
      sel_ok   = 1'b1;
      case (source_q)
         // General-purpose line, gated by its direction
         SRC_LINE1: begin
            sel_now  = sync2_q[3];
            sel_prev = prev_q[3];
            sel_ok   = gpio_dir_q;
         end
         // Camera control lines, already in active-high sense
         SRC_CC1: begin
            sel_now  = sync2_q[2];
            sel_prev = prev_q[2];
         end
         SRC_CC2: begin
            sel_now  = sync2_q[1];
            sel_prev = prev_q[1];
         end
         SRC_CC3: begin
            sel_now  = sync2_q[0];
            sel_prev = prev_q[0];
         end
         // Software or unused code: no hardware edge
         default: begin
            sel_ok = 1'b0;
         end
      endcase
   end

   // One-cycle edge pulse by polarity
   // Mode off masks edges here, so nothing is remembered across a disable
   logic hw_edge; // Qualified edge on the selected input
   assign hw_edge = mode_q && sel_ok &&
      (falling_q ? (sel_prev && !sel_now) : (!sel_prev && sel_now));

   // Registered copy of the edge for the outside world; it shows the edge
   // before any delay, so a frame grabber can time the delay itself
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ext_pulse_q <= 1'b0;
      end else begin
         ext_pulse_q <= hw_edge;
      end
   end
   assign ext_acq_start_pulse = ext_pulse_q;

   // Delay timer: microsecond prescaler plus microsecond counter
   // Only one delay runs at a time; edges that land while it runs are dropped,
   // so a trigger train faster than the delay loses all but its first edge
   logic               dly_busy_q; // Delay in progress
   logic [15:0]        pre_q;      // Cycles left in this microsecond
   logic [DELAY_W-1:0] us_q;       // Whole microseconds left after this one
   logic               dly_start;  // Edge that opens a delay
   logic               hw_fire;    // Hardware trigger takes effect
   // Edges in frame wait are refused, so they open no delay either
   assign dly_start = hw_edge && delay_q != '0 && !dly_busy_q && state_q == ST_WAIT_ACQ;
   // Zero delay bypasses the timer altogether
   assign hw_fire = (hw_edge && delay_q == '0) ||
                    (dly_busy_q && us_q == '0 && pre_q == '0);
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         dly_busy_q <= 1'b0;
         pre_q      <= 16'h0000;
         us_q       <= '0;
      end else if (!mode_q) begin
         // Disabled mode cancels any pending delay
         dly_busy_q <= 1'b0;
      end else if (dly_start) begin
         dly_busy_q <= 1'b1;
         pre_q      <= 16'(CYC_US - 1);
         us_q       <= delay_q - 1'b1;
      end else if (dly_busy_q) begin
         if (pre_q != '0) begin
            pre_q <= pre_q - 1'b1;
         end else if (us_q != '0) begin
            pre_q <= 16'(CYC_US - 1);
            us_q  <= us_q - 1'b1;
         end else begin
            // Last microsecond done; hw_fire is high in this cycle
            dly_busy_q <= 1'b0;
         end
      end
   end

   // Arm state machine and frame count
   logic acq_fire;
   logic frm_ok;
   assign acq_fire = soft_fire || hw_fire;
   assign frm_ok   = (state_q == ST_WAIT_FRM) && frame_trig;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_q  <= ST_IDLE;
         frames_q <= '0;
      end else begin
         case (state_q)
            // Disabled: frame triggers pass straight through
            ST_IDLE: begin
               if (mode_q) begin
                  state_q <= ST_WAIT_ACQ;
               end
            end
            ST_WAIT_ACQ: begin
               // Frame triggers ignored here
               frames_q <= '0;
               if (!mode_q) state_q <= ST_IDLE;
               else if (acq_fire) state_q <= ST_WAIT_FRM;
            end
            // Armed: count frames up to the programmed number
            ST_WAIT_FRM: begin
               if (!mode_q) begin
                  state_q <= ST_IDLE;
               end else if (frm_ok) begin
                  // Greater-or-equal also catches a count lowered mid-acquisition
                  if (frames_q + 1'b1 >= frame_cnt_q) begin
                     frames_q <= '0;
                     state_q  <= ST_WAIT_ACQ;
                  end else begin
                     frames_q <= frames_q + 1'b1;
                  end
               end
            end
            // Unused code falls back to idle
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Frame start: passes through in free mode, gated when armed
   // Triggers that arrive while waiting for a start are lost, not queued
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         frame_start_q <= 1'b0;
      end else begin
         frame_start_q <= mode_q ? frm_ok : frame_trig;
      end
   end
   assign frame_start = frame_start_q;
   // Armed flag is a decode of the state flop, free of glitches
   assign acq_armed   = (state_q == ST_WAIT_FRM);

   // Read mux, data one cycle after strobe
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rdata_q <= 32'h0000_0000;
      end else if (bus.rd) begin
         case (bus.addr)
            ADDR_MODE:       rdata_q <= {31'h0, mode_q};
            ADDR_SOURCE:     rdata_q <= {29'h0, source_q};
            ADDR_ACTIVATION: rdata_q <= {31'h0, falling_q};
            ADDR_FRAME_CNT:  rdata_q <= {24'h0, frame_cnt_q};
            ADDR_DELAY:      rdata_q <= {12'h0, delay_q};
            ADDR_SOFT_TRIG:  rdata_q <= {31'h0, soft_q};
            ADDR_SELECTOR:   rdata_q <= {30'h0, selector_q};
            ADDR_GPIO_DIR:   rdata_q <= {31'h0, gpio_dir_q};
            // Status packs state, delay busy and frame count
            ADDR_STATUS:     rdata_q <= {12'h0, frames_q, 7'h0, dly_busy_q,
                                         2'h0, state_q};
            default:         rdata_q <= 32'h0000_0000;
         endcase
      end else begin
         // Zero outside the answer cycle, so several slaves can be ORed
         rdata_q <= 32'h0000_0000;
      end
   end
   assign rdata = rdata_q;
endmodule // ast_trigger_ctrl
`default_nettype wire

// file: test/ast_trigger_ctrl_checker.sv
// Checker: port timing relations of the trigger controller
`timescale 1ns/10ps
`default_nettype none
module ast_trigger_ctrl_checker
   import ast_pkg::*;
(
   input wire logic        clock,
   input wire logic        rst,
   input wire ast_bus_type bus,
   input wire logic [31:0] rdata,
   input wire ast_hw_type  hw_in,
   input wire logic        frame_trig,
   input wire logic        frame_start,
   input wire logic        acq_armed,
   input wire logic        ext_acq_start_pulse,
   input wire logic        gpio_direction_select
);
   logic [5:0] chg_q; // Pin change history, newest in bit 0
   ast_hw_type hw_q;  // Pin levels one cycle back
   // Pin change history; covers the synchroniser depth
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         chg_q <= 6'h00;
         hw_q  <= '{line1: 1'b0, cc1_n: 1'b1, cc2_n: 1'b1, cc3_n: 1'b1}; // Idle pin levels
      end else begin
         chg_q <= {chg_q[4:0], hw_in != hw_q};
         hw_q  <= hw_in;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // Status read request
   sequence s_rd_status;
      bus.rd && bus.addr == ADDR_STATUS;
   endsequence
   a_pulse_single: assert property (ext_acq_start_pulse |=> !ext_acq_start_pulse)
      else $error("edge pulse longer than one cycle");
   a_pulse_cause: assert property (ext_acq_start_pulse |-> |chg_q)
      else $error("edge pulse without a pin change");
   a_frame_cause: assert property (frame_start |-> $past(frame_trig))
      else $error("frame start without a frame trigger");
   a_frame_follow: assert property (frame_trig && acq_armed |=> frame_start)
      else $error("frame trigger dropped while armed");
   a_armed_hold: assert property (acq_armed && !frame_trig && !bus.wr |=> acq_armed)
      else $error("left frame wait without a frame");
   a_rdata_zero: assert property (!$past(bus.rd) |-> rdata == 32'h0)
      else $error("read data outside the answer cycle");
   a_dir_write: assert property (bus.wr && bus.addr == ADDR_GPIO_DIR |=>
      gpio_direction_select == $past(bus.wdata[0]))
      else $error("direction register not written");
   a_st_armed: assert property (s_rd_status ##0 acq_armed |=> rdata[1:0] == 2'h3)
      else $error("status does not show frame wait");
   a_st_waiting: assert property (s_rd_status ##0 !acq_armed |=> rdata[1:0] != 2'h3)
      else $error("status shows frame wait while not armed");
endmodule // ast_trigger_ctrl_checker
`default_nettype wire

// file: test/ast_hw_source.sv
// Partner model: external trigger source and frame trigger source
`timescale 1ns/10ps
`default_nettype none
module ast_hw_source
   import ast_pkg::*;
(
   input  wire logic     clock,
   output var ast_hw_type hw_in,
   output logic          frame_trig
);
   logic [3:0] lvl_q = 4'h0; // Logical levels: line1, cc1, cc2, cc3
   initial frame_trig = 1'b0;
   // Control lines idle high; pins carry the inverted level
   assign hw_in = {lvl_q[3], ~lvl_q[2:0]};
   // Change one logical level just after an edge
   task automatic set_lvl(input int i, input logic v);
      @(posedge clock) lvl_q[i] <= v;
   endtask
   // Frame trigger pulses, gap sets how slowly they come
   task automatic frames(input int n, input int gap);
      repeat (n) begin
         @(posedge clock) frame_trig <= 1'b1;
         @(posedge clock) frame_trig <= 1'b0;
         repeat (gap) @(posedge clock);
      end
   endtask
endmodule // ast_hw_source
`default_nettype wire

// file: test/ast_trigger_ctrl_tb_top.sv
// Testbench top: register tasks and trigger scenarios
`timescale 1ns/10ps
`default_nettype none
module ast_trigger_ctrl_tb_top
   import ast_pkg::*;
;
   logic        clock = 1'b0; // 100 MHz
   logic        rst = 1'b1;   // Held for 16 cycles
   ast_bus_type bus = '0;     // Register requests
   logic [31:0] rdata;        // Read answer
   logic [31:0] d;            // Last read value
   ast_hw_type  hw_in;        // Trigger pins
   logic        frame_trig, frame_start, acq_armed, ext_pulse, gpio_dir;
   int          n_fail = 0;
   int          samples_checked = 0;
   int          n_frm = 0;    // Frame starts seen
   int          n_ext = 0;    // Edge pulses seen
   always #5 clock = ~clock;
   // Count frame starts and edge pulses
   always @(posedge clock) if (frame_start === 1'b1) n_frm <= n_frm + 1;
   always @(posedge clock) if (ext_pulse === 1'b1) n_ext <= n_ext + 1;
   ast_trigger_ctrl #(.CYC_US(2)) uut (.clock(clock), .rst(rst), .bus(bus), .rdata(rdata), .hw_in(hw_in),
      .frame_trig(frame_trig), .frame_start(frame_start), .acq_armed(acq_armed),
      .ext_acq_start_pulse(ext_pulse), .gpio_direction_select(gpio_dir));
   ast_hw_source hw (.clock(clock), .hw_in(hw_in), .frame_trig(frame_trig));
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clock) bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clock) bus <= '0;
   endtask
   // Read, then compare the answer cycle
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      @(posedge clock) bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clock) bus <= '0;
      #1 d = rdata;
      chk(d, e);
   endtask
   // Bounded wait for the armed flag
   task automatic wait_arm(input logic e, input int n);
      int k;
      k = 0;
      while (acq_armed !== e && k < n) @(posedge clock) #1 k = k + 1;
      chk({31'h0, acq_armed}, {31'h0, e});
   endtask
   task automatic tend(input string t);
      $display("test %0s done", t);
   endtask
   task automatic summarize();
      $display("compares %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Watchdog, far beyond the few hundred cycles expected
   initial begin
      #300000;
      n_fail++;
      summarize();
   end
   initial begin
      int n0;
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      for (int i = 0; i < 10; i++) rdc(8'(i * 4), 32'(i == 3));
      hw.frames(1, 2);
      chk(n_frm, 1);
      tend("reset");
      wr(ADDR_MODE, 1);
      n0 = n_frm;
      hw.frames(2, 1);
      chk(n_frm - n0, 0);
      rdc(ADDR_STATUS, 1);
      wr(ADDR_FRAME_CNT, 2);
      wr(ADDR_SOFT_TRIG, 1);
      wait_arm(1, 4);
      rdc(ADDR_STATUS, 32'h3);
      rdc(ADDR_SOFT_TRIG, 0);
      n0 = n_frm;
      hw.frames(3, 0);
      chk(n_frm - n0, 2);
      chk(acq_armed, 0);
      tend("soft");
      wr(ADDR_SELECTOR, SEL_FRAME_START);
      wr(ADDR_SOFT_TRIG, 1);
      repeat (4) @(posedge clock);
      chk(acq_armed, 0);
      wr(ADDR_SELECTOR, SEL_ACQ_START);
      wr(ADDR_FRAME_CNT, 0);
      rdc(ADDR_FRAME_CNT, 1);
      wr(ADDR_FRAME_CNT, 255);
      rdc(ADDR_FRAME_CNT, 255);
      wr(ADDR_FRAME_CNT, 1);
      tend("selector");
      wr(ADDR_SOURCE, SRC_LINE1);
      hw.set_lvl(3, 1);
      repeat (8) @(posedge clock);
      chk(acq_armed, 0);
      hw.set_lvl(3, 0);
      wr(ADDR_GPIO_DIR, 1);
      rdc(ADDR_GPIO_DIR, 1);
      chk(gpio_dir, 1);
      for (int s = 1; s <= 4; s++) begin
         for (int f = 0; f < 2; f++) begin
            wr(ADDR_SOURCE, SRC_SOFTWARE);
            hw.set_lvl(4 - s, f[0]);
            wr(ADDR_ACTIVATION, f);
            wr(ADDR_SOURCE, s);
            hw.set_lvl((5 - s) % 4, 1'b1);
            hw.set_lvl((5 - s) % 4, 1'b0);
            repeat (6) @(posedge clock);
            chk(acq_armed, 0);
            hw.set_lvl(4 - s, !f[0]);
            wait_arm(1, 8);
            hw.frames(1, 0);
            wait_arm(0, 3);
         end
      end
      chk(n_ext, 8);
      tend("hardware");
      wr(ADDR_DELAY, 5);
      // Rising edge on the third control line, still the selected source
      wr(ADDR_ACTIVATION, 0);
      hw.set_lvl(0, 1);
      repeat (8) @(posedge clock);
      chk(acq_armed, 0);
      wait_arm(1, 20);
      hw.frames(1, 0);
      wr(ADDR_SOURCE, SRC_SOFTWARE);
      wr(ADDR_SOFT_TRIG, 1);
      wait_arm(1, 3);
      tend("delay");
      summarize();
   end
endmodule // ast_trigger_ctrl_tb_top
bind ast_trigger_ctrl ast_trigger_ctrl_checker u_chk (.clock(clock), .rst(rst), .bus(bus), .rdata(rdata),
   .hw_in(hw_in), .frame_trig(frame_trig), .frame_start(frame_start), .acq_armed(acq_armed),
   .ext_acq_start_pulse(ext_acq_start_pulse), .gpio_direction_select(gpio_direction_select));
`default_nettype wire
